// file: design/swb_pkg.sv
package swb_pkg;
	// register offsets
	localparam logic [7:0] OFS_CONFIG  = 8'h33;
	localparam logic [7:0] OFS_BUTTONS = 8'h34;
	localparam logic [7:0] OFS_BATTERY = 8'h35;
	localparam logic [7:0] OFS_PIN_OUTPUT_ENABLE_REG = 8'h30;
	localparam logic [7:0] OFS_IO_DOUT = 8'h31;
	// field positions
	localparam int BIT_BOOT   = 0;
	localparam int BIT_SLEEP  = 1;
	localparam int BIT_LOWIND = 2;
	localparam int BIT_DEAD   = 3;
	localparam int BIT_VALID  = 6;
	localparam int BIT_LOW    = 7;
	localparam int BIT_HYST   = 6;
	localparam int NUM_PINS   = 6;
	localparam int LEVEL_W    = 6;
	// reset values
	localparam logic [7:0] RST_BYTE = 8'h00;
	// timing
	localparam int XTAL_HZ         = 20_000_000;
	localparam int MEAS_MAX_CYC    = 3100;
	localparam int SETTLE_CYC_DEF  = 64;
	localparam int OSC_START_CYC   = 16;
	localparam int CNT_W           = 12;
	typedef enum logic [2:0] {
		ST_RUN,
		ST_ASLEEP,
		ST_OSC_START,
		ST_WAKE_CHECK,
		ST_BOOT_RESET
	} swb_state_type;
endpackage : swb_pkg

// file: design/swb_meas_if.sv
`timescale 1ns/1ps
// measurement request and result between top and measurement engine
interface swb_meas_if;
	logic start;
	logic busy;
	logic done;
	logic result_low;
	modport ctrl (output start, input busy, input done, input result_low);
	modport eng  (input start, output busy, output done, output result_low);
endinterface : swb_meas_if

// file: design/swb_meas.sv
`timescale 1ns/1ps
// waits a settling count then samples the comparator once
module swb_meas
	import swb_pkg::*;
#(
	parameter int SETTLE_CYC = SETTLE_CYC_DEF
)(
	input  wire logic clk,
	input  wire logic rstn,
	input  wire logic cmp_low,
	swb_meas_if.eng   m
);
	initial
	begin
		if (SETTLE_CYC < 1 || SETTLE_CYC >= MEAS_MAX_CYC)
			$error("settling count out of range");
	end
	logic [CNT_W-1:0] cnt_r;
	// settle counter; a new start restarts it
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			cnt_r <= '0;
			m.busy <= 1'b0;
			m.done <= 1'b0;
			m.result_low <= 1'b0;
		end
		else
		begin
			m.done <= 1'b0;
			if (m.start)
			begin
				m.busy <= 1'b1;
				cnt_r <= CNT_W'(SETTLE_CYC - 1);
			end
			else if (m.busy)
			begin
				if (cnt_r == '0)
				begin
					m.busy <= 1'b0;
					m.done <= 1'b1;
					m.result_low <= cmp_low;
				end
				else
					cnt_r <= cnt_r - 1'b1;
			end
		end
	end
	// cycles since the last start, to bound a pending measurement
	logic [CNT_W-1:0] age_r;
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			age_r <= '0;
		else if (m.start)
			age_r <= '0;
		else if (m.busy)
			age_r <= age_r + 1'b1;
	end
	// a measurement never stays busy past the allowed bound
	settle_time_a: assert property (
		@(posedge clk) disable iff (!rstn)
		m.busy |-> age_r < CNT_W'(MEAS_MAX_CYC))
		else $error("measurement did not finish in time");
endmodule : swb_meas

// file: design/swb_top.sv
`timescale 1ns/1ps
module swb_top
	import swb_pkg::*;
#(
	parameter int SETTLE_CYC = SETTLE_CYC_DEF
)(
	input  wire logic                         clk,
	input  wire logic                         rstn,
	input  wire logic [7:0]                   addr,
	input  wire logic [7:0]                   wdata,
	input  wire logic                         wr,
	input  wire logic                         rd,
	output logic [7:0]                        rdata,
	input  wire logic [swb_pkg::NUM_PINS-1:0] pin_in,
	input  wire logic                         cmp_low,
	input  wire logic                         batt_dead,
	output logic [swb_pkg::LEVEL_W-1:0]       cmp_level,
	output logic                              cmp_large_hyst,
	output logic                              osc_en,
	output logic                              sysclk_en,
	output logic                              wdt_run,
	output logic                              cpu_boot_reset,
	output logic [swb_pkg::NUM_PINS-1:0]      pin_out,
	output logic [swb_pkg::NUM_PINS-1:0]      pin_oe
);
	import swb_pkg::*;
	initial
	begin
		if (SETTLE_CYC < 1 || SETTLE_CYC + OSC_START_CYC >= MEAS_MAX_CYC)
			$error("settling count out of range");
	end

	swb_state_type        state_r;
	logic [7:0]           pin_output_enable_reg_r;
	logic [NUM_PINS-1:0]  io_dout_r;
	logic                 boot_mode_r;
	logic [NUM_PINS-1:0]  detect_r;
	logic [LEVEL_W-1:0]   level_r;
	logic                 valid_r;
	logic                 low_r;
	logic                 sleep_req_r;
	logic [4:0]           osc_cnt_r;
	logic                 sw_meas_r;
	logic [CNT_W-1:0]     pend_cyc_r;
	logic [NUM_PINS-1:0]  buttons;
	logic [NUM_PINS-1:0]  pressed;
	logic                 any_press;
	logic                 wr_cfg;
	logic                 wr_btn;
	logic                 wr_bat;

	swb_meas_if mif ();

	// all checks below run on clk and rest while reset is low
	default clocking chk_cb @(posedge clk);
	endclocking
	default disable iff (!rstn);

	// pin role decode
	function automatic logic [NUM_PINS-1:0] button_mask(
		input logic [NUM_PINS-1:0] oe,
		input logic [NUM_PINS-1:0] dout
	);
		button_mask = ~oe & dout;
	endfunction : button_mask

	assign buttons   = button_mask(pin_output_enable_reg_r[NUM_PINS-1:0], io_dout_r);
	assign pressed   = buttons & ~pin_in;
	assign any_press = |pressed;
	assign wr_cfg    = wr && addr == OFS_CONFIG;
	assign wr_btn    = wr && addr == OFS_BUTTONS;
	assign wr_bat    = wr && addr == OFS_BATTERY;

	// io enable and data out registers
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			pin_output_enable_reg_r <= RST_BYTE;
			io_dout_r <= '0;
		end
		else
		begin
			if (wr && addr == OFS_PIN_OUTPUT_ENABLE_REG)
				pin_output_enable_reg_r <= wdata;
			if (wr && addr == OFS_IO_DOUT)
				io_dout_r <= wdata[NUM_PINS-1:0];
		end
	end

	// sleep request lands the cycle after the write
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			sleep_req_r <= 1'b0;
		else
			sleep_req_r <= wr_cfg && wdata[BIT_SLEEP];
	end

	// sleep and wake sequencer
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			state_r   <= ST_RUN;
			osc_cnt_r <= '0;
		end
		else
		begin
			unique case (state_r)
				ST_RUN:
					if (sleep_req_r)
						state_r <= ST_ASLEEP;
				ST_ASLEEP:
					if (any_press)
					begin
						state_r   <= ST_OSC_START;
						osc_cnt_r <= 5'(OSC_START_CYC - 1);
					end
				ST_OSC_START:
					if (osc_cnt_r == '0)
						state_r <= ST_WAKE_CHECK;
					else
						osc_cnt_r <= osc_cnt_r - 1'b1;
				ST_WAKE_CHECK:
					if (mif.done)
					begin
						if (batt_dead)
							state_r <= ST_ASLEEP;
						else if (boot_mode_r)
							state_r <= ST_BOOT_RESET;
						else
							state_r <= ST_RUN;
					end
				ST_BOOT_RESET:
					state_r <= ST_RUN;
				default:
					state_r <= ST_RUN;
			endcase
		end
	end

	// measurement start: wake check or register write
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			sw_meas_r <= 1'b0;
		else if (wr_bat)
			sw_meas_r <= 1'b1;
		else if (mif.done)
			sw_meas_r <= 1'b0;
	end

	// age of a software measurement, to bound its valid flag
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			pend_cyc_r <= '0;
		else if (wr_bat)
			pend_cyc_r <= '0;
		else if (sw_meas_r && !valid_r)
			pend_cyc_r <= pend_cyc_r + 1'b1;
	end
	assign mif.start = wr_bat
		|| (state_r == ST_OSC_START && osc_cnt_r == '0);

	swb_meas #(
		.SETTLE_CYC (SETTLE_CYC)
	) u_meas (
		.clk     (clk),
		.rstn    (rstn),
		.cmp_low (cmp_low),
		.m       (mif)
	);

	// battery config: level, valid, result
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			level_r <= '0;
			valid_r <= 1'b0;
			low_r   <= 1'b0;
		end
		else if (wr_bat)
		begin
			level_r <= wdata[LEVEL_W-1:0];
			valid_r <= 1'b0;
		end
		else if (mif.done && !mif.start)
		begin
			valid_r <= 1'b1;
			low_r   <= mif.result_low;
		end
	end

	// boot mode bit
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			boot_mode_r <= 1'b0;
		else if (state_r == ST_BOOT_RESET)
			boot_mode_r <= 1'b0;
		else if (wr_cfg)
			boot_mode_r <= wdata[BIT_BOOT];
	end

	// button detect flags, set wins over software clear
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			detect_r <= '0;
		else
		begin
			for (int i = 0; i < NUM_PINS; i++)
			begin
				if (pressed[i] && !batt_dead)
					detect_r[i] <= 1'b1;
				else if (wr_btn && !wdata[i])
					detect_r[i] <= 1'b0;
			end
		end
	end

	// read data, one cycle after the strobe
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			rdata <= RST_BYTE;
		else if (rd)
		begin
			rdata <= RST_BYTE;
			unique case (addr)
				OFS_CONFIG:
				begin
					rdata[BIT_BOOT]   <= boot_mode_r;
					rdata[BIT_LOWIND] <= low_r;
					rdata[BIT_DEAD]   <= batt_dead;
				end
				OFS_BUTTONS:
					rdata[NUM_PINS-1:0] <= detect_r;
				OFS_BATTERY:
					rdata <= {low_r, valid_r, level_r};
				OFS_PIN_OUTPUT_ENABLE_REG:
					rdata <= pin_output_enable_reg_r;
				OFS_IO_DOUT:
					rdata[NUM_PINS-1:0] <= io_dout_r;
				default:
					rdata <= RST_BYTE;
			endcase
		end
		else
			rdata <= RST_BYTE;
	end

	// registered outputs
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			cmp_level      <= '0;
			cmp_large_hyst <= 1'b0;
			osc_en         <= 1'b1;
			sysclk_en      <= 1'b1;
			wdt_run        <= 1'b1;
			cpu_boot_reset <= 1'b0;
			pin_out        <= '0;
			pin_oe         <= '0;
		end
		else
		begin
			cmp_level      <= level_r;
			cmp_large_hyst <= pin_output_enable_reg_r[BIT_HYST];
			osc_en         <= state_r != ST_ASLEEP;
			sysclk_en      <= state_r == ST_RUN
				|| state_r == ST_BOOT_RESET;
			wdt_run        <= state_r == ST_RUN;
			cpu_boot_reset <= state_r == ST_BOOT_RESET;
			pin_out        <= io_dout_r;
			pin_oe         <= pin_output_enable_reg_r[NUM_PINS-1:0];
		end
	end

	// sleep stops the oscillator three edges after the write
	sequence sleep_write_s;
		wr_cfg && wdata[BIT_SLEEP] && state_r == ST_RUN;
	endsequence
	// wake check finishing, split by the battery verdict
	sequence check_dead_s;
		state_r == ST_WAKE_CHECK && mif.done && batt_dead;
	endsequence
	sequence check_good_s;
		state_r == ST_WAKE_CHECK && mif.done && !batt_dead;
	endsequence
	sleep_stop_a: assert property (sleep_write_s
		|-> ##3 !osc_en && !wdt_run)
		else $error("sleep did not stop oscillator");
	wdt_hold_a: assert property (state_r != ST_RUN
		|-> ##1 !wdt_run)
		else $error("watchdog ran while not awake");
	// compare with the flag as it stood when the read was taken
	mirror_bit_a: assert property (rd && addr == OFS_CONFIG
		|=> rdata[BIT_LOWIND] == $past(low_r))
		else $error("low indicator mismatch");
	sleep_reads_a: assert property (rd && addr == OFS_CONFIG
		|=> !rdata[BIT_SLEEP])
		else $error("sleep bit read back set");
	valid_clear_a: assert property (wr_bat |=> !valid_r)
		else $error("write did not clear valid");
	low_latch_a: assert property (mif.done && !mif.start && !wr_bat
		|=> low_r == $past(mif.result_low) && valid_r)
		else $error("result not latched");
	valid_due_a: assert property (sw_meas_r
		|-> pend_cyc_r < CNT_W'(MEAS_MAX_CYC))
		else $error("battery result overdue");
	level_out_a: assert property (wr_bat
		|=> ##1 cmp_level == $past(wdata[LEVEL_W-1:0], 2))
		else $error("level not driven to comparator");
	hyst_out_a: assert property (
		cmp_large_hyst == $past(pin_output_enable_reg_r[BIT_HYST]))
		else $error("hysteresis request mismatch");
	dead_resleep_a: assert property (check_dead_s
		|=> state_r == ST_ASLEEP ##1 !osc_en)
		else $error("dead battery did not resleep");
	good_wake_a: assert property (check_good_s |=> ##1 sysclk_en)
		else $error("good battery did not start clock");
	boot_clear_a: assert property (state_r == ST_BOOT_RESET
		|=> !boot_mode_r ##1 !cpu_boot_reset)
		else $error("boot mode not cleared");
	// every pressed button pin, not one fixed pin
	detect_set_a: assert property (any_press && !batt_dead
		|=> (detect_r & $past(pressed)) == $past(pressed))
		else $error("detect bit not set");
	wake_press_a: assert property (state_r == ST_ASLEEP && any_press
		|=> state_r == ST_OSC_START)
		else $error("button did not wake");
	upper_zero_a: assert property (rd && addr == OFS_BUTTONS
		|=> rdata[7:6] == 2'h0)
		else $error("upper detect bits not zero");
endmodule : swb_top

// file: dv/swb_batt_model.sv
`timescale 1ns/1ps
// supply comparator and dead sense, registered like a synchronizer
module swb_batt_model
	import swb_pkg::*;
(
	input  wire logic                       clk,
	input  wire logic                       rstn,
	input  wire logic [swb_pkg::LEVEL_W-1:0] cmp_level,
	input  wire logic [swb_pkg::LEVEL_W-1:0] supply_code,
	input  wire logic                       dead_in,
	output logic                            cmp_low,
	output logic                            batt_dead
);
	// a higher code trips at a lower voltage
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			cmp_low   <= 1'b0;
			batt_dead <= 1'b0;
		end
		else
		begin
			cmp_low   <= (cmp_level < supply_code);
			batt_dead <= dead_in;
		end
	end
endmodule : swb_batt_model

// file: dv/swb_top_tb.sv
`timescale 1ns/1ps
// self-checking bench for sleep, wake and battery sampling
module swb_top_tb;
	import swb_pkg::*;
	logic                clk     = 1'b0;
	logic                rstn    = 1'b0;
	logic [7:0]          addr    = 8'h00;
	logic [7:0]          wdata   = 8'h00;
	logic                wr      = 1'b0;
	logic                rd      = 1'b0;
	logic [NUM_PINS-1:0] press   = '0;
	logic [LEVEL_W-1:0]  supply  = 6'h20;
	logic                dead_in = 1'b0;
	logic [7:0]          rdata;
	logic [7:0]          got;
	logic [LEVEL_W-1:0]  lvl;
	logic [LEVEL_W-1:0]  cmp_level;
	logic [NUM_PINS-1:0] pin_out;
	logic [NUM_PINS-1:0] pin_oe;
	logic                cmp_low;
	logic                batt_dead;
	logic                cmp_large_hyst;
	logic                osc_en;
	logic                sysclk_en;
	logic                wdt_run;
	logic                cpu_boot_reset;
	wire  [NUM_PINS-1:0] pin_in;
	wire  [2:0]          outs;
	int                  err_total = 0;
	int                  tests_run = 0;
	int                  cyc       = 0;
	int                  i;
	// pad level: driven value, else the button pulls it low
	assign pin_in = (pin_oe & pin_out) | (~pin_oe & ~press);
	assign outs   = {cpu_boot_reset, sysclk_en, osc_en};
	always #25 clk = ~clk;
	swb_top #(.SETTLE_CYC(4)) dut_u (.clk(clk), .rstn(rstn), .addr(addr),
		.wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .pin_in(pin_in),
		.cmp_low(cmp_low), .batt_dead(batt_dead), .cmp_level(cmp_level),
		.cmp_large_hyst(cmp_large_hyst), .osc_en(osc_en),
		.sysclk_en(sysclk_en), .wdt_run(wdt_run),
		.cpu_boot_reset(cpu_boot_reset), .pin_out(pin_out), .pin_oe(pin_oe));
	swb_batt_model batt_u (.clk(clk), .rstn(rstn), .cmp_level(cmp_level),
		.supply_code(supply), .dead_in(dead_in), .cmp_low(cmp_low),
		.batt_dead(batt_dead));
	// cycle ceiling against a hang
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 30000)
		begin
			err_total++;
			wrap_up();
		end
	end
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : wrap_up
	task automatic chk8(input logic [7:0] g, input logic [7:0] e);
		tests_run++;
		if (g !== e)
		begin
			$display("FAIL t=%0t got=%h exp=%h", $time, g, e);
			err_total++;
		end
	endtask : chk8
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wr_reg
	task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		addr <= a;
		rd   <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		d = rdata;
	endtask : rd_reg
	// bounded wait until outs[w] reaches v
	task automatic wait_out(input int w, input logic v);
		int k;
		for (k = 0; k < 300; k++)
		begin
			@(posedge clk);
			#1;
			if (outs[w] === v)
				break;
		end
	endtask : wait_out
	// load a level, poll valid, then judge the result
	task automatic meas(input logic [LEVEL_W-1:0] l);
		int k;
		logic [7:0] cfg;
		wr_reg(OFS_BATTERY, {2'b00, l});
		rd_reg(OFS_BATTERY, got);
		chk8(got & 8'h40, 8'h00);
		for (k = 0; k < 1550 && got[BIT_VALID] !== 1'b1; k++)
			rd_reg(OFS_BATTERY, got);
		chk8(got & 8'h40, 8'h40);
		chk8({7'h00, got[BIT_LOW]}, {7'h00, l < supply});
		chk8({2'b00, cmp_level}, {2'b00, l});
		rd_reg(OFS_CONFIG, cfg);
		chk8({7'h00, cfg[BIT_LOWIND]}, {7'h00, got[BIT_LOW]});
	endtask : meas
	initial
	begin
		void'($urandom(32'hCCD2));
		repeat (20) @(posedge clk);
		rstn <= 1'b1;
		rd_reg(OFS_BUTTONS, got);
		chk8(got, RST_BYTE);
		rd_reg(OFS_BATTERY, got);
		chk8(got, RST_BYTE);
		rd_reg(OFS_CONFIG, got);
		chk8(got, RST_BYTE);
		$display("test reset done");
		for (i = 0; i < 12; i++)
		begin
			lvl = (i == 0) ? 6'h00 : (i == 1) ? 6'h3F : 6'($urandom);
			@(posedge clk);
			supply <= (i == 1) ? 6'h00 : 6'($urandom);
			meas(lvl);
		end
		$display("test battery done");
		// pin0 output low, pin1 plain input, pins 5:2 buttons
		wr_reg(OFS_PIN_OUTPUT_ENABLE_REG, 8'h41);
		wr_reg(OFS_IO_DOUT, 8'h3C);
		chk8({7'h00, cmp_large_hyst}, 8'h01);
		press <= 6'h3F;
		repeat (4) @(posedge clk);
		chk8({2'b00, pin_out}, 8'h3C);
		chk8({2'b00, pin_oe}, 8'h01);
		press <= 6'h00;
		rd_reg(OFS_BUTTONS, got);
		chk8(got, 8'h3C);
		wr_reg(OFS_BUTTONS, 8'hFF);
		rd_reg(OFS_BUTTONS, got);
		chk8(got, 8'h3C);
		wr_reg(OFS_BUTTONS, 8'hC3);
		rd_reg(OFS_BUTTONS, got);
		chk8(got, 8'h00);
		$display("test buttons done");
		// sleep with a dead battery, then wake with a good one
		dead_in <= 1'b1;
		wr_reg(OFS_CONFIG, 8'h02);
		repeat (4) @(posedge clk);
		#1;
		chk8({5'h00, osc_en, sysclk_en, wdt_run}, 8'h00);
		press <= 6'h04;
		wait_out(0, 1'b1);
		chk8({7'h00, osc_en}, 8'h01);
		press <= 6'h00;
		wait_out(0, 1'b0);
		chk8({5'h00, osc_en, sysclk_en, wdt_run}, 8'h00);
		dead_in <= 1'b0;
		press   <= 6'h08;
		wait_out(1, 1'b1);
		chk8({5'h00, osc_en, sysclk_en, wdt_run}, 8'h07);
		press <= 6'h00;
		rd_reg(OFS_BUTTONS, got);
		chk8(got, 8'h08);
		rd_reg(OFS_CONFIG, got);
		chk8(got & 8'h03, 8'h00);
		$display("test sleep done");
		// boot mode wake gives one reset pulse and clears the mode
		wr_reg(OFS_CONFIG, 8'h01);
		wr_reg(OFS_CONFIG, 8'h03);
		repeat (4) @(posedge clk);
		press <= 6'h10;
		wait_out(2, 1'b1);
		chk8({7'h00, cpu_boot_reset}, 8'h01);
		press <= 6'h00;
		wait_out(1, 1'b1);
		rd_reg(OFS_CONFIG, got);
		chk8(got & 8'h01, 8'h00);
		rd_reg(OFS_BATTERY, got);
		chk8(got & 8'h3F, {2'b00, lvl});
		$display("test boot done");
		wrap_up();
	end
endmodule : swb_top_tb
